// ===== rcs_cpl_framer.sv
// Requester completion stream framer with its AHB-Lite control registers
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Stream width is 64, 128 or 256 bits, beats shaped to it.
// - No-data completion: one beat at 128/256, two beats at 64.
// - Valid stays high on every beat of a packet unless the payload source runs dry.
// - A stalled beat keeps data and sideband until ready returns.
// - One keep bit per Dword, contiguous, zeros only in last beat.
// - Keep also covers null Dwords between descriptor and payload.
// - Last is high in the final beat of each packet only.
// - First start flag marks the beat carrying the descriptor start.
// - Dword-aligned: three descriptor Dwords then payload, one packet.
// - Payload over two Dwords is one contiguous byte run.
// - Per-byte enables mark payload bytes only, never descriptor or null.
// - Enables contiguous except for payloads of two Dwords or less.
// - Zero-length read: one payload Dword with all enables low.
// - Address-aligned: payload starts in the beat after the descriptor.
// - Address-aligned: first payload byte may sit on any lane.
// - Address-aligned: first payload Dword lane set by request offset.
// - Start Dword address sits in lower address bits 6 down to 2.
// - Address-aligned mode never straddles; packets follow one another.
// - Abort flag in the last beat means the whole packet is discarded.
// - Request-completed bit 30 set in the last completion of a request.
module rcs_cpl_framer #(
	parameter int DATA_W = 256
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic cpl_desc_valid,
	output logic cpl_desc_ready,
	input wire logic [95:0] cpl_desc,
	input wire logic [3:0] cpl_first_be,
	input wire logic [3:0] cpl_last_be,
	input wire logic [2:0] cpl_addr_offset,
	input wire logic cpl_req_done,
	input wire logic cpl_zero_len,
	input wire logic cpl_abort,
	input wire logic cpl_pay_valid,
	output logic cpl_pay_ready,
	input wire logic [DATA_W-1:0] cpl_pay_data,
	output logic cpl_stream_valid,
	input wire logic cpl_stream_ready,
	output logic [DATA_W-1:0] cpl_stream_payload,
	output logic [DATA_W/32-1:0] cpl_stream_keep,
	output logic cpl_stream_last,
	output logic [rcs_pkg::SB_W-1:0] cpl_stream_sideband
);
	localparam int N = DATA_W / 32;
	localparam int LOG2N = $clog2(N);
	// Descriptor rounded up to whole beats; the payload of aligned mode starts after it
	localparam int HDR_DWS = ((rcs_pkg::DESC_DWS + N - 1) / N) * N;
	localparam int VW = rcs_pkg::VI_W;

	if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256)
	begin : g_width_check
		$error("Stream width must be 64, 128 or 256 bits");
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	rcs_pkg::rcs_state_type state_q;
	rcs_pkg::rcs_state_type state_d;
	logic [31:0] ctrl_q;
	logic desc_ready_q;
	logic desc_take;
	logic [10:0] in_dwc;
	logic has_pay;
	logic [VW-1:0] in_p;
	logic [VW-1:0] in_t;
	logic [VW-1:0] in_nin;
	logic [3:0] e_first;
	logic [3:0] e_last;
	logic [95:0] desc_q;
	logic [VW-1:0] p_q;
	logic [VW-1:0] t_q;
	logic [VW-1:0] nin_q;
	logic [2:0] rot_q;
	logic [3:0] fbe_q;
	logic [3:0] lbe_q;
	logic zero_q;
	logic abort_q;
	logic pay_q;
	logic [VW-1:0] base_q;
	logic [VW-1:0] popcnt_q;
	logic need_cur;
	logic out_free;
	logic build;
	logic pop;
	logic is_last;
	logic [DATA_W-1:0] a_q;
	logic [DATA_W-1:0] a_d;
	logic [DATA_W-1:0] b_q;
	logic [DATA_W-1:0] b_d;
	logic [DATA_W-1:0] carry_q;
	logic a_v_q;
	logic a_v_d;
	logic b_v_q;
	logic b_v_d;
	logic a_stay;
	logic push;
	logic pay_ready_q;
	logic valid_q;
	logic last_q;
	logic sof_q;
	logic disc_q;
	logic [4*N-1:0] be_lanes;
	logic ahb_take;
	logic sel_ctrl;
	logic sel_stat;
	logic wr_pend_q;
	logic [31:0] ctrl_view;
	logic [31:0] stat_word;
	logic [31:0] rd_word;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic stall_q;
	logic [4:0] ladw_q;
	logic [15:0] pkt_cnt_q;

	rcs_beat_if #(.N(N)) bi ();

	////////////////////////////////////////////////////////////////////////////
	// Descriptor intake

	assign desc_take = cpl_desc_valid && desc_ready_q;
	assign in_dwc = cpl_desc[rcs_pkg::D_DWC_LO +: rcs_pkg::D_DWC_W];
	assign has_pay = in_dwc != 11'h000;
	// Aligned mode pads to the next beat, then to the requested lane
	assign in_p = (ctrl_q[rcs_pkg::CTRL_ALIGN] && has_pay) ?
		VW'(HDR_DWS) + VW'(cpl_addr_offset & 3'(N - 1)) :
		VW'(rcs_pkg::DESC_DWS);
	assign in_t = in_p + VW'(in_dwc);
	assign in_nin = VW'((in_dwc + 11'(N - 1)) >> LOG2N);

	rcs_edge_be u_edge (
		.la(cpl_desc[1:0]),
		.bc(cpl_desc[rcs_pkg::D_BC_LO +: rcs_pkg::D_BC_W]),
		.dwc(in_dwc),
		.fbe(cpl_first_be),
		.lbe(cpl_last_be),
		.first_be(e_first),
		.last_be(e_last)
	);

	always_ff @(posedge mclk)
	begin
		if (desc_take)
		begin
			desc_q <= {cpl_desc[95:rcs_pkg::D_DONE+1], cpl_req_done,
				cpl_desc[rcs_pkg::D_DONE-1:0]};
			p_q <= in_p;
			t_q <= in_t;
			nin_q <= in_nin;
			rot_q <= 3'(in_p) & 3'(N - 1);
			fbe_q <= e_first;
			lbe_q <= e_last;
			zero_q <= cpl_zero_len;
			abort_q <= cpl_abort;
			pay_q <= has_pay;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Packet sequencing

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			rcs_pkg::S_IDLE:
				if (desc_take)
					state_d = rcs_pkg::S_FRAME;
			rcs_pkg::S_FRAME:
				if (build && is_last)
					state_d = rcs_pkg::S_IDLE;
			default:
				state_d = rcs_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_q <= rcs_pkg::S_IDLE;
			desc_ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			// Next packet only after the previous last beat is built
			desc_ready_q <= (state_d == rcs_pkg::S_IDLE) && ctrl_q[rcs_pkg::CTRL_EN];
		end
	end

	// A beat from the first payload beat on needs the current input beat while payload input remains
	assign need_cur = (popcnt_q < nin_q) && (base_q >= p_q - VW'(rot_q));
	assign out_free = (base_q == '0) ? !valid_q : (!valid_q || cpl_stream_ready);
	assign build = (state_q == rcs_pkg::S_FRAME) && out_free && (!need_cur || a_v_q);
	assign pop = build && need_cur;
	assign is_last = base_q + VW'(N) >= t_q;

	always_ff @(posedge mclk)
	begin
		if (rst || desc_take)
		begin
			base_q <= '0;
			popcnt_q <= '0;
		end
		else if (build)
		begin
			base_q <= base_q + VW'(N);
			popcnt_q <= popcnt_q + VW'(pop);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Payload intake: two beats deep so that ready can come from a flop

	assign push = cpl_pay_valid && pay_ready_q;
	assign a_stay = a_v_q && !pop;

	always_comb
	begin
		a_d = a_q;
		b_d = b_q;
		a_v_d = a_v_q;
		b_v_d = b_v_q;
		if (!a_stay)
		begin
			a_d = b_v_q ? b_q : cpl_pay_data;
			a_v_d = b_v_q || push;
			b_d = cpl_pay_data;
			b_v_d = b_v_q && push;
		end
		else if (push)
		begin
			b_d = cpl_pay_data;
			b_v_d = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		a_q <= a_d;
		b_q <= b_d;
		if (pop)
			carry_q <= a_q;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			a_v_q <= 1'b0;
			b_v_q <= 1'b0;
			pay_ready_q <= 1'b0;
		end
		else
		begin
			a_v_q <= a_v_d;
			b_v_q <= b_v_d;
			pay_ready_q <= !b_v_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Beat assembly

	assign bi.load = build;
	assign bi.base = base_q;
	assign bi.pay_start = p_q;
	assign bi.pkt_end = t_q;
	assign bi.rot = rot_q;
	assign bi.desc = desc_q;
	assign bi.cur = a_q;
	assign bi.carry = carry_q;
	assign bi.be_first = fbe_q;
	assign bi.be_last = lbe_q;
	assign bi.zero_be = zero_q || !pay_q;

	for (genvar j = 0; j < N; j++)
	begin : g_lane
		rcs_lane_slot #(.J(j), .N(N)) u_slot (
			.mclk(mclk),
			.rst(rst),
			.bi(bi),
			.dw_q(cpl_stream_payload[32*j +: 32]),
			.keep_q(cpl_stream_keep[j]),
			.be_q(be_lanes[4*j +: 4])
		);
	end

	// Valid falls only between packets or if the payload source runs dry
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			valid_q <= 1'b0;
			last_q <= 1'b0;
			sof_q <= 1'b0;
			disc_q <= 1'b0;
		end
		else if (build)
		begin
			valid_q <= 1'b1;
			last_q <= is_last;
			sof_q <= base_q == '0;
			disc_q <= is_last && abort_q && pay_q;
		end
		else if (cpl_stream_ready)
		begin
			valid_q <= 1'b0;
		end
	end

	assign cpl_stream_valid = valid_q;
	assign cpl_stream_last = last_q;
	assign cpl_stream_sideband[31:0] = 32'(be_lanes);
	assign cpl_stream_sideband[rcs_pkg::SB_SOF0] = sof_q;
	// Straddle is not built: these fields always read zero
	assign cpl_stream_sideband[rcs_pkg::SB_SOF1] = 1'b0;
	assign cpl_stream_sideband[rcs_pkg::SB_EOF0 +: 4] = 4'h0;
	assign cpl_stream_sideband[rcs_pkg::SB_EOF1 +: 4] = 4'h0;
	assign cpl_stream_sideband[rcs_pkg::SB_DISC] = disc_q;
	assign cpl_desc_ready = desc_ready_q;
	assign cpl_pay_ready = pay_ready_q;

	////////////////////////////////////////////////////////////////////////////
	// Status capture

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			stall_q <= 1'b0;
			ladw_q <= 5'h00;
			pkt_cnt_q <= 16'h0000;
		end
		else
		begin
			stall_q <= valid_q && !cpl_stream_ready;
			if (desc_take)
				ladw_q <= cpl_desc[rcs_pkg::D_LA_DW_LO +: rcs_pkg::D_LA_DW_W];
			if (valid_q && cpl_stream_ready && last_q)
				pkt_cnt_q <= pkt_cnt_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states; upper address bits are not decoded

	assign ahb_take = hsel && htrans[1] && hready;
	assign sel_ctrl = haddr[7:0] == rcs_pkg::REG_CTRL;
	assign sel_stat = haddr[7:0] == rcs_pkg::REG_STAT;
	// A read right behind a write to the control word sees the new value
	assign ctrl_view = wr_pend_q ? (hwdata & rcs_pkg::CTRL_MASK) : ctrl_q;
	assign stat_word = {pkt_cnt_q, 3'h0, ladw_q, 6'h00, stall_q,
		state_q == rcs_pkg::S_FRAME};
	assign rd_word = sel_ctrl ? ctrl_view : (sel_stat ? stat_word : 32'h00000000);

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= ahb_take && hwrite && sel_ctrl;
			if (ahb_take && !hwrite)
				hrdata_q <= rd_word;
		end
	end

	// Mode is only looked at when a descriptor is taken; enable gates descriptor ready every cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			ctrl_q <= rcs_pkg::CTRL_RST;
		else if (wr_pend_q)
			ctrl_q <= hwdata & rcs_pkg::CTRL_MASK;
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
endmodule

// ===== rcs_pkg.sv
// Shared constants and types of the requester completion stream framer
package rcs_pkg;
	localparam int DW_W = 32;
	localparam int DESC_DWS = 3;
	localparam int VI_W = 12;
	localparam int SB_W = 43;
	localparam int SB_SOF0 = 32;
	localparam int SB_SOF1 = 33;
	localparam int SB_EOF0 = 34;
	localparam int SB_EOF1 = 38;
	localparam int SB_DISC = 42;
	localparam int D_LA_DW_LO = 2;
	localparam int D_LA_DW_W = 5;
	localparam int D_BC_LO = 16;
	localparam int D_BC_W = 13;
	localparam int D_DONE = 30;
	localparam int D_DWC_LO = 32;
	localparam int D_DWC_W = 11;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] CTRL_MASK = 32'h00000003;
	localparam int CTRL_ALIGN = 0;
	localparam int CTRL_EN = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_STALL = 1;
	localparam int ST_LADW_LO = 8;
	localparam int ST_CNT_LO = 16;
	typedef enum logic [0:0] {S_IDLE, S_FRAME} rcs_state_type;
endpackage

// ===== rcs_beat_if.sv
// Beat build context passed from the framer to its lane slots
`timescale 1ns/1ns
interface rcs_beat_if #(parameter int N = 8);
	logic load;
	logic [rcs_pkg::VI_W-1:0] base;
	logic [rcs_pkg::VI_W-1:0] pay_start;
	logic [rcs_pkg::VI_W-1:0] pkt_end;
	logic [2:0] rot;
	logic [rcs_pkg::DESC_DWS*rcs_pkg::DW_W-1:0] desc;
	logic [N*rcs_pkg::DW_W-1:0] cur;
	logic [N*rcs_pkg::DW_W-1:0] carry;
	logic [3:0] be_first;
	logic [3:0] be_last;
	logic zero_be;
	modport src (output load, base, pay_start, pkt_end, rot, desc, cur, carry,
		be_first, be_last, zero_be);
	modport lane (input load, base, pay_start, pkt_end, rot, desc, cur, carry,
		be_first, be_last, zero_be);
endinterface

// ===== rcs_lane_slot.sv
// One Dword lane of the outgoing beat: content select and output register
`timescale 1ns/1ns
module rcs_lane_slot #(
	parameter int J = 0,
	parameter int N = 8
) (
	input wire logic mclk,
	input wire logic rst,
	rcs_beat_if.lane bi,
	output logic [rcs_pkg::DW_W-1:0] dw_q,
	output logic keep_q,
	output logic [3:0] be_q
);
	logic [rcs_pkg::VI_W-1:0] v;
	logic in_desc;
	logic in_pkt;
	logic in_pay;
	logic from_cur;
	logic [2:0] sel;
	logic [31:0] desc_dw;
	logic [31:0] pay_dw;
	logic [31:0] dw_d;
	logic [3:0] be_d;

	// Virtual Dword index of this lane within the packet
	assign v = bi.base + rcs_pkg::VI_W'(J);
	assign in_desc = v < rcs_pkg::VI_W'(rcs_pkg::DESC_DWS);
	assign in_pkt = v < bi.pkt_end;
	assign in_pay = in_pkt && (v >= bi.pay_start);
	// Lanes below the rotation come from the previous input beat
	assign from_cur = 3'(J) >= bi.rot;
	assign sel = 3'(J) - bi.rot + (from_cur ? 3'h0 : 3'(N));
	assign desc_dw = v[1] ? bi.desc[95:64] : (v[0] ? bi.desc[63:32] : bi.desc[31:0]);
	assign pay_dw = from_cur ? bi.cur[32*sel +: 32] : bi.carry[32*sel +: 32];
	assign dw_d = in_desc ? desc_dw : (in_pay ? pay_dw : 32'h00000000);
	assign be_d = (!in_pay || bi.zero_be) ? 4'h0 :
		(v == bi.pay_start) ? bi.be_first :
		(v == bi.pkt_end - rcs_pkg::VI_W'(1)) ? bi.be_last : 4'hF;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dw_q <= 32'h00000000;
			keep_q <= 1'b0;
			be_q <= 4'h0;
		end
		else if (bi.load)
		begin
			dw_q <= dw_d;
			keep_q <= in_pkt;
			be_q <= be_d;
		end
	end
endmodule

// ===== rcs_edge_be.sv
// Byte enables of the first and last payload Dword of a completion
`timescale 1ns/1ns
module rcs_edge_be (
	input wire logic [1:0] la,
	input wire logic [12:0] bc,
	input wire logic [10:0] dwc,
	input wire logic [3:0] fbe,
	input wire logic [3:0] lbe,
	output logic [3:0] first_be,
	output logic [3:0] last_be
);
	logic wide;
	logic [13:0] span;
	logic [1:0] end_b;

	assign wide = dwc > 11'h002;
	assign span = {12'h000, la} + {1'b0, bc};
	assign end_b = 2'(span - 14'h0001);
	// Long payloads are one byte run bounded by lower address and byte count
	assign first_be = wide ? (4'hF << la) : fbe;
	assign last_be = !wide ? lbe :
		(span >= {1'b0, dwc, 2'b00}) ? 4'hF : (4'hF >> (2'h3 - end_b));
endmodule

// ===== rcs_cpl_framer_props.sv
// Stream framing checks on the completion framer's user-side ports
`timescale 1ns/1ns
module rcs_cpl_framer_props #(
	parameter int DATA_W = 256
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cpl_stream_valid,
	input wire logic cpl_stream_ready,
	input wire logic [DATA_W-1:0] cpl_stream_payload,
	input wire logic [DATA_W/32-1:0] cpl_stream_keep,
	input wire logic cpl_stream_last,
	input wire logic [rcs_pkg::SB_W-1:0] cpl_stream_sideband
);
	logic in_pkt_q;
	logic in_pkt_d;
	logic moved;
	assign moved = cpl_stream_valid && cpl_stream_ready;
	assign in_pkt_d = moved ? !cpl_stream_last : in_pkt_q;
	always_ff @(posedge mclk)
	begin
		if (rst)
			in_pkt_q <= 1'b0;
		else
			in_pkt_q <= in_pkt_d;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence stalled;
		cpl_stream_valid && !cpl_stream_ready;
	endsequence
	sequence moved_mid;
		moved && !cpl_stream_last;
	endsequence
	sequence moved_end;
		moved && cpl_stream_last;
	endsequence
	AST_VALID_RUN: assert property (moved_mid |=> cpl_stream_valid)
		else $error("valid dropped inside a packet");
	AST_STALL_HOLD: assert property (stalled |=> cpl_stream_valid &&
		$stable(cpl_stream_payload) && $stable(cpl_stream_keep) &&
		$stable(cpl_stream_last) && $stable(cpl_stream_sideband))
		else $error("stalled beat changed");
	AST_KEEP_FULL: assert property (cpl_stream_valid && !cpl_stream_last |-> &cpl_stream_keep)
		else $error("keep not full before last beat");
	AST_KEEP_RUN: assert property (cpl_stream_valid |-> cpl_stream_keep[0] &&
		((cpl_stream_keep + 1'b1) & cpl_stream_keep) == '0)
		else $error("keep not contiguous from lane 0");
	AST_SOF_FIRST: assert property (cpl_stream_valid |->
		cpl_stream_sideband[rcs_pkg::SB_SOF0] == !in_pkt_q)
		else $error("start flag not on first beat only");
	AST_BE_DESC: assert property (cpl_stream_valid && cpl_stream_sideband[rcs_pkg::SB_SOF0]
		|-> cpl_stream_sideband[11:0] == 12'h000)
		else $error("byte enable on descriptor lanes");
	AST_NO_STRADDLE: assert property (cpl_stream_valid |->
		cpl_stream_sideband[41:33] == 9'h000)
		else $error("straddle fields active");
	AST_DISC_LAST: assert property (cpl_stream_valid &&
		cpl_stream_sideband[rcs_pkg::SB_DISC] |-> cpl_stream_last)
		else $error("abort flag outside last beat");
	AST_PKT_GAP: assert property (moved_end |=> !cpl_stream_valid)
		else $error("packet started in the beat after last");
endmodule
bind rcs_cpl_framer rcs_cpl_framer_props #(.DATA_W(DATA_W)) props_i (
	.mclk(mclk),
	.rst(rst),
	.cpl_stream_valid(cpl_stream_valid),
	.cpl_stream_ready(cpl_stream_ready),
	.cpl_stream_payload(cpl_stream_payload),
	.cpl_stream_keep(cpl_stream_keep),
	.cpl_stream_last(cpl_stream_last),
	.cpl_stream_sideband(cpl_stream_sideband)
);

// ===== rcs_sink_model.sv
// User-side consumer of the completion stream, logging up to four beats
`timescale 1ns/1ns
module rcs_sink_model #(
	parameter int DATA_W = 256
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic slow,
	input wire logic clear,
	input wire logic valid,
	input wire logic [DATA_W-1:0] payload,
	input wire logic [DATA_W/32-1:0] keep,
	input wire logic last,
	input wire logic [rcs_pkg::SB_W-1:0] sideband,
	output logic ready
);
	logic [1:0] phase_q;
	logic [DATA_W-1:0] dat [4];
	logic [DATA_W/32-1:0] kp [4];
	logic [rcs_pkg::SB_W-1:0] sb [4];
	logic lst [4];
	logic [2:0] nb;
	logic done;
	// Slow mode stalls three cycles of four to stress the hold rule
	assign ready = !slow || phase_q == 2'b11;
	always @(posedge mclk)
	begin
		phase_q <= rst ? 2'b00 : phase_q + 2'b01;
		if (rst || clear)
		begin
			nb <= 3'h0;
			done <= 1'b0;
		end
		else if (valid && ready)
		begin
			// Lane enables used in place of retained request enables
			dat[nb[1:0]] <= payload;
			kp[nb[1:0]] <= keep;
			sb[nb[1:0]] <= sideband;
			lst[nb[1:0]] <= last;
			nb <= nb + 3'h1;
			done <= last;
		end
	end
endmodule

// ===== tb.sv
// Self-checking bench of the completion framer at 256 bits
`timescale 1ns/1ns
module tb;
	logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, off;
	logic cpl_desc_valid, cpl_desc_ready, cpl_req_done, cpl_zero_len, cpl_abort;
	logic [95:0] cpl_desc;
	logic [3:0] cpl_first_be, cpl_last_be;
	logic cpl_pay_valid, cpl_pay_ready, cpl_stream_valid, cpl_stream_ready;
	logic [255:0] cpl_pay_data, cpl_stream_payload;
	logic [7:0] cpl_stream_keep;
	logic cpl_stream_last, slow, clear;
	logic [rcs_pkg::SB_W-1:0] cpl_stream_sideband;
	int n_errors = 0;
	int comparisons = 0;
	assign hready = hreadyout;
	rcs_cpl_framer #(.DATA_W(256)) rcs_cpl_framer_i (.mclk(mclk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.cpl_desc_valid(cpl_desc_valid), .cpl_desc_ready(cpl_desc_ready),
		.cpl_desc(cpl_desc), .cpl_first_be(cpl_first_be), .cpl_last_be(cpl_last_be),
		.cpl_addr_offset(off), .cpl_req_done(cpl_req_done), .cpl_zero_len(cpl_zero_len),
		.cpl_abort(cpl_abort), .cpl_pay_valid(cpl_pay_valid), .cpl_pay_ready(cpl_pay_ready),
		.cpl_pay_data(cpl_pay_data), .cpl_stream_valid(cpl_stream_valid),
		.cpl_stream_ready(cpl_stream_ready), .cpl_stream_payload(cpl_stream_payload),
		.cpl_stream_keep(cpl_stream_keep), .cpl_stream_last(cpl_stream_last),
		.cpl_stream_sideband(cpl_stream_sideband));
	rcs_sink_model #(.DATA_W(256)) sink_i (.mclk(mclk), .rst(rst), .slow(slow),
		.clear(clear), .valid(cpl_stream_valid), .payload(cpl_stream_payload),
		.keep(cpl_stream_keep), .last(cpl_stream_last), .sideband(cpl_stream_sideband),
		.ready(cpl_stream_ready));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Payload goes ahead of the descriptor so no beat waits on data
	task automatic send(input logic [10:0] dwc, input logic [12:0] bc, input logic [11:0] la,
		input logic [2:0] ofs, input logic [2:0] fl, input logic [2:0] nbeats);
		int t = 0;
		clear <= 1'b1;
		@(posedge mclk);
		clear <= 1'b0;
		cpl_pay_valid <= dwc != 11'h000;
		for (int b = 0; b < (dwc + 7) / 8; b++)
		begin
			for (int j = 0; j < 8; j++)
				cpl_pay_data[j*32 +: 32] <= 32'hA0000000 + 32'(b * 8 + j);
			do @(posedge mclk); while (cpl_pay_ready !== 1'b1);
		end
		cpl_pay_valid <= 1'b0;
		cpl_desc <= {53'h0, dwc, 3'h2, bc, 4'h0, la};
		off <= ofs;
		{cpl_req_done, cpl_zero_len, cpl_abort} <= fl;
		cpl_desc_valid <= 1'b1;
		do @(posedge mclk); while (cpl_desc_ready !== 1'b1);
		cpl_desc_valid <= 1'b0;
		cpl_desc <= ~cpl_desc;
		t = 0;
		while (sink_i.done !== 1'b1 && ++t < 300) @(posedge mclk);
		chk("done", sink_i.done, 1'b1);
		chk("beats", sink_i.nb, nbeats);
	endtask
	task automatic beat(input int i, input logic [7:0] k, input logic l, input logic [31:0] be);
		chk("keep", sink_i.kp[i], k);
		chk("last", sink_i.lst[i], l);
		chk("byte_en", sink_i.sb[i][31:0], be);
		chk("sof", sink_i.sb[i][rcs_pkg::SB_SOF0], i == 0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		ahb(1'b0, 8'h00, 32'h0);
		chk("ctrl_reset", rd, 32'h0);
		ahb(1'b1, 8'h00, 32'h2);
		ahb(1'b0, 8'h00, 32'h0);
		chk("ctrl", rd, 32'h2);
		ahb(1'b1, 8'h04, 32'hFFFF);
		ahb(1'b0, 8'h04, 32'h0);
		chk("stat_busy", rd[0], 1'b0);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("regs done");
	endtask
	task automatic t_nodata();
		send(11'd0, 13'd0, 12'h000, 3'd0, 3'b101, 3'd1);
		beat(0, 8'h07, 1'b1, 32'h0);
		chk("no_abort", sink_i.sb[0][rcs_pkg::SB_DISC], 1'b0);
		chk("req_done", sink_i.dat[0][30], 1'b1);
		$display("nodata done");
	endtask
	task automatic t_dw5();
		slow <= 1'b1;
		send(11'd5, 13'd20, 12'h000, 3'd0, 3'b000, 3'd1);
		slow <= 1'b0;
		beat(0, 8'hFF, 1'b1, 32'hFFFFF000);
		chk("pay_lane3", sink_i.dat[0][127:96], 32'hA0000000);
		chk("req_open", sink_i.dat[0][30], 1'b0);
		$display("dw5 done");
	endtask
	task automatic t_dw10();
		send(11'd10, 13'd39, 12'h001, 3'd0, 3'b101, 3'd2);
		beat(0, 8'hFF, 1'b0, 32'hFFFFE000);
		beat(1, 8'h1F, 1'b1, 32'h000FFFFF);
		chk("pay_beat1", sink_i.dat[1][31:0], 32'hA0000005);
		chk("abort_mid", sink_i.sb[0][rcs_pkg::SB_DISC], 1'b0);
		chk("abort_end", sink_i.sb[1][rcs_pkg::SB_DISC], 1'b1);
		$display("dw10 done");
	endtask
	task automatic t_zero();
		send(11'd1, 13'd1, 12'h000, 3'd0, 3'b010, 3'd1);
		beat(0, 8'h0F, 1'b1, 32'h0);
		$display("zero length done");
	endtask
	task automatic t_align();
		ahb(1'b1, 8'h00, 32'h3);
		send(11'd2, 13'd8, 12'h014, 3'd5, 3'b000, 3'd2);
		beat(0, 8'hFF, 1'b0, 32'h0);
		beat(1, 8'h7F, 1'b1, 32'h03F00000);
		chk("lower_dw", sink_i.dat[0][6:2], 5'd5);
		chk("pay_lane5", sink_i.dat[1][191:160], 32'hA0000000);
		ahb(1'b0, 8'h04, 32'h0);
		chk("stat_ladw", rd[12:8], 5'h05);
		chk("stat_pkts", rd[31:16], 16'h0005);
		$display("aligned done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		wrap_up();
	end
	initial
	begin
		{rst, slow, clear} = 3'b100;
		{hsel, hwrite, htrans, haddr, hwdata, hsize} = {36'h0, 32'h0, 3'b010};
		{cpl_desc_valid, cpl_pay_valid, cpl_req_done, cpl_zero_len, cpl_abort} = 5'h00;
		{cpl_desc, cpl_pay_data, off} = '0;
		cpl_first_be = 4'hF;
		cpl_last_be = 4'h3;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs();
		t_nodata();
		t_dw5();
		t_dw10();
		t_zero();
		t_align();
		wrap_up();
	end
endmodule
